/* rtl/fsq_pkg.sv */
// constants shared by the flash command sequencer
package fsq_pkg;
    // ------------------------------------------------------------
    // apb register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_RADDR = 8'h04;
    localparam logic [7:0] OFF_RDATA = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_CTRL = 8'h10;
    localparam logic [7:0] OFF_PROTECT = 8'h14;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CMD_ADDR_LSB = 16;
    localparam int CTRL_SUPPLY_BIT = 0;
    localparam int ST_ERR1 = 1;
    localparam int ST_ERR3 = 3;
    localparam int ST_ERR4 = 4;
    localparam int ST_ERR5 = 5;
    localparam int ST_READY = 7;
    localparam logic [7:0] ST_ERR_MASK = 8'h3A;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] RST_CMD = 32'h0000_0000;
    localparam logic [7:0] RST_RADDR = 8'h00;
    localparam logic [7:0] RST_ERR = 8'h00;
    localparam logic RST_SUPPLY = 1'b0;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;
    // ------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------
    localparam logic [7:0] C_PRG_ALT = 8'h10;
    localparam logic [7:0] C_ERS_SETUP = 8'h20;
    localparam logic [7:0] C_PRG_SETUP = 8'h40;
    localparam logic [7:0] C_CLR_STATUS = 8'h50;
    localparam logic [7:0] C_RD_STATUS = 8'h70;
    localparam logic [7:0] C_RD_SIG = 8'h90;
    localparam logic [7:0] C_RD_QUERY = 8'h98;
    localparam logic [7:0] C_SUSPEND = 8'hB0;
    localparam logic [7:0] C_BCK_SETUP = 8'hBC;
    localparam logic [7:0] C_BCK_CONFIRM = 8'hCB;
    localparam logic [7:0] C_CONFIRM = 8'hD0;
    localparam logic [7:0] C_BUF_SETUP = 8'hE8;
    localparam logic [7:0] C_RD_ARRAY = 8'hFF;
    // ------------------------------------------------------------
    // sizes and timing
    // ------------------------------------------------------------
    localparam int BUF_WORDS = 32;
    localparam int OP_TICK_DIV = 4;
    // ------------------------------------------------------------
    // bank read modes and sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_ARRAY = 2'b00,
        MODE_STATUS = 2'b01,
        MODE_SIG = 2'b10,
        MODE_QUERY = 2'b11
    } fsq_mode_t;
    typedef enum logic [10:0] {
        S_IDLE = 11'b000_0000_0001,
        S_ERS_SET = 11'b000_0000_0010,
        S_BCK_SET = 11'b000_0000_0100,
        S_PRG_SET = 11'b000_0000_1000,
        S_BUF_CNT = 11'b000_0001_0000,
        S_BUF_LOAD = 11'b000_0010_0000,
        S_BUF_CONF = 11'b000_0100_0000,
        S_ERASE = 11'b000_1000_0000,
        S_BLANK = 11'b001_0000_0000,
        S_PROG = 11'b010_0000_0000,
        S_BUF_PROG = 11'b100_0000_0000
    } fsq_state_t;
endpackage : fsq_pkg

/* rtl/fsq_wbuf.sv */
// write buffer holding the words of one buffered program
module fsq_wbuf #(
    parameter int DEPTH = fsq_pkg::BUF_WORDS,
    parameter int DW = 16
) (
    input wire logic pclk,
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_idx,
    input wire logic [DW-1:0] wr_data,
    input wire logic [$clog2(DEPTH)-1:0] rd_idx,
    output logic [DW-1:0] rd_data
);
    import fsq_pkg::*;

    // no reset: contents only count after a full load sequence
    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge pclk) begin
        if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
    end

    assign rd_data = mem[rd_idx];
endmodule : fsq_wbuf

/* rtl/fsq_seq.sv */
// flash command sequencer: erase, blank check, word and buffered program
module fsq_seq #(
    parameter int ADDR_W = 8,
    parameter int BLOCK_W = 6,
    parameter int BANK_W = 7,
    parameter int TICK_DIV = fsq_pkg::OP_TICK_DIV
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic reset_pin_n
);
    import fsq_pkg::*;

    localparam int NBLK = 1 << (ADDR_W - BLOCK_W);
    localparam int NBANK = 1 << (ADDR_W - BANK_W);
    localparam int WORDS = 1 << ADDR_W;
    localparam int BI_W = $clog2(BUF_WORDS);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        fsq_state_t state;
        logic [NBANK-1:0][1:0] bank_mode;
        logic [7:0] err;
        logic [ADDR_W-1:0] op_addr;
        logic [15:0] op_data;
        logic [BLOCK_W-1:0] op_idx;
        logic [BI_W-1:0] buf_n;
        logic [ADDR_W-1:0] buf_start;
        logic [BI_W:0] buf_left;
        logic buf_started;
        logic [7:0] div_cnt;
        logic [31:0] cmd;
        logic [7:0] raddr;
        logic supply;
        logic [NBLK-1:0] protect;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } fsq_regs_t;

    fsq_regs_t r;
    fsq_regs_t next_r;
    logic [15:0] mem [WORDS];
    logic mem_we;
    logic [ADDR_W-1:0] mem_wa;
    logic [15:0] mem_wd;
    logic buf_we;
    logic [BI_W-1:0] buf_wi;
    logic [BI_W-1:0] buf_ri;
    logic [15:0] buf_rd;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic reg_hit(input logic [7:0] a);
        if (a == OFF_CMD) begin
            return 1'b1;
        end else if (a == OFF_RADDR || a == OFF_RDATA || a == OFF_STATUS) begin
            return 1'b1;
        end else if (a == OFF_CTRL || a == OFF_PROTECT) begin
            return 1'b1;
        end else begin
            return 1'b0;
        end
    endfunction : reg_hit

    function automatic logic [ADDR_W-BLOCK_W-1:0] blk_of(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:BLOCK_W];
    endfunction : blk_of

    function automatic logic [ADDR_W-BANK_W-1:0] bank_of(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:BANK_W];
    endfunction : bank_of

    function automatic logic is_busy(input fsq_state_t s);
        return (s == S_ERASE) || (s == S_BLANK) || (s == S_PROG) || (s == S_BUF_PROG);
    endfunction : is_busy

    fsq_wbuf #(
        .DEPTH(BUF_WORDS),
        .DW(16)
    ) u_wbuf (
        .pclk(pclk),
        .wr_en(buf_we),
        .wr_idx(buf_wi),
        .wr_data(pwdata[15:0]),
        .rd_idx(buf_ri),
        .rd_data(buf_rd)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic tick;
        logic wr_acc;
        logic cmd_wr;
        logic [ADDR_W-1:0] ca;
        logic [15:0] cd;
        logic [7:0] code;
        logic [7:0] stat;
        logic [ADDR_W-1:0] ridx;
        logic read_cmd;
        tick = 1'b0;
        wr_acc = 1'b0;
        cmd_wr = 1'b0;
        ca = '0;
        cd = '0;
        code = '0;
        stat = '0;
        ridx = '0;
        read_cmd = 1'b0;
        next_r = r;
        mem_we = 1'b0;
        mem_wa = r.op_addr;
        mem_wd = ERASED_WORD;
        buf_we = 1'b0;
        buf_wi = '0;
        buf_ri = r.op_idx[BI_W-1:0];

        // slow tick paces the internal controller
        tick = (r.div_cnt == 8'(TICK_DIV - 1));
        next_r.div_cnt = tick ? 8'h00 : 8'(r.div_cnt + 8'h01);

        // ready bit tracks the controller, not the host sequence
        stat = r.err;
        stat[ST_READY] = ~is_busy(r.state);

        // apb: answer registered in the setup cycle, one access cycle
        next_r.pready = psel & ~penable;
        next_r.pslverr = psel & ~penable & ~reg_hit(paddr);
        if (psel && !penable && !pwrite) begin
            if (paddr == OFF_CMD) begin
                next_r.prdata = r.cmd;
            end else if (paddr == OFF_RADDR) begin
                next_r.prdata = {24'h00_0000, r.raddr};
            end else if (paddr == OFF_RDATA) begin
                next_r.prdata = 32'h0000_0000;
                if (r.bank_mode[bank_of(r.raddr[ADDR_W-1:0])] == MODE_STATUS) begin
                    next_r.prdata = {24'h00_0000, stat};
                end else if (r.bank_mode[bank_of(r.raddr[ADDR_W-1:0])] == MODE_ARRAY) begin
                    next_r.prdata = {16'h0000, mem[r.raddr[ADDR_W-1:0]]};
                end
            end else if (paddr == OFF_STATUS) begin
                next_r.prdata = {24'h00_0000, stat};
            end else if (paddr == OFF_CTRL) begin
                next_r.prdata = {31'h0000_0000, r.supply};
            end else if (paddr == OFF_PROTECT) begin
                next_r.prdata = {{(32-NBLK){1'b0}}, r.protect};
            end else begin
                next_r.prdata = 32'h0000_0000;
            end
        end

        wr_acc = psel & penable & r.pready & pwrite;
        if (wr_acc) begin
            if (paddr == OFF_CMD) begin
                cmd_wr = 1'b1;
                next_r.cmd = pwdata;
            end else if (paddr == OFF_RADDR) begin
                next_r.raddr = pwdata[7:0];
            end else if (paddr == OFF_CTRL) begin
                next_r.supply = pwdata[CTRL_SUPPLY_BIT];
            end else if (paddr == OFF_PROTECT) begin
                next_r.protect = pwdata[NBLK-1:0];
            end
        end
        ca = pwdata[CMD_ADDR_LSB +: ADDR_W];
        cd = pwdata[15:0];
        code = pwdata[7:0];
        read_cmd = (code == C_RD_ARRAY) || (code == C_RD_STATUS) ||
                   (code == C_RD_SIG) || (code == C_RD_QUERY);

        // ------------------------------------------------------------
        // internal controller, one word per tick
        // ------------------------------------------------------------
        if (tick) begin
            case (r.state)
                S_ERASE: begin
                    mem_we = 1'b1;
                    mem_wa = {blk_of(r.op_addr), r.op_idx};
                    mem_wd = ERASED_WORD;
                    next_r.op_idx = r.op_idx + 1'b1;
                    if (&r.op_idx) begin
                        next_r.state = S_IDLE;
                    end
                end
                S_BLANK: begin
                    ridx = {blk_of(r.op_addr), r.op_idx};
                    next_r.op_idx = r.op_idx + 1'b1;
                    if (mem[ridx] != ERASED_WORD) begin
                        next_r.err[ST_ERR5] = 1'b1;
                        next_r.state = S_IDLE;
                    end else if (&r.op_idx) begin
                        next_r.state = S_IDLE;
                    end
                end
                S_PROG: begin
                    mem_we = 1'b1;
                    mem_wa = r.op_addr;
                    mem_wd = mem[r.op_addr] & r.op_data; // programming only clears bits
                    next_r.state = S_IDLE;
                end
                S_BUF_PROG: begin
                    ridx = ADDR_W'(r.buf_start + ADDR_W'(r.op_idx));
                    mem_we = 1'b1;
                    mem_wa = ridx;
                    mem_wd = mem[ridx] & buf_rd;
                    next_r.op_idx = r.op_idx + 1'b1;
                    if (r.op_idx[BI_W-1:0] == r.buf_n) begin
                        next_r.state = S_IDLE;
                    end
                end
                default: begin
                end
            endcase
        end

        // ------------------------------------------------------------
        // command interface
        // ------------------------------------------------------------
        if (cmd_wr) begin
            case (r.state)
                S_IDLE: begin
                    next_r.op_addr = ca;
                    next_r.op_idx = '0;
                    if (code == C_CLR_STATUS) begin
                        next_r.err = next_r.err & ~ST_ERR_MASK;
                    end else if (code == C_RD_ARRAY) begin
                        next_r.bank_mode[bank_of(ca)] = MODE_ARRAY;
                    end else if (code == C_RD_STATUS) begin
                        next_r.bank_mode[bank_of(ca)] = MODE_STATUS;
                    end else if (code == C_RD_SIG) begin
                        next_r.bank_mode[bank_of(ca)] = MODE_SIG;
                    end else if (code == C_RD_QUERY) begin
                        next_r.bank_mode[bank_of(ca)] = MODE_QUERY;
                    end else if (code == C_ERS_SETUP) begin
                        next_r.state = S_ERS_SET;
                    end else if (code == C_PRG_SETUP || code == C_PRG_ALT) begin
                        next_r.state = S_PRG_SET;
                    end else if (code == C_BCK_SETUP && r.supply) begin
                        next_r.state = S_BCK_SET;
                    end else if (code == C_BUF_SETUP) begin
                        next_r.state = S_BUF_CNT;
                        next_r.bank_mode[bank_of(ca)] = MODE_STATUS;
                    end
                end
                S_ERS_SET: begin
                    next_r.state = S_IDLE;
                    next_r.op_addr = ca;
                    next_r.op_idx = '0;
                    next_r.bank_mode[bank_of(ca)] = MODE_STATUS;
                    if (code != C_CONFIRM) begin
                        next_r.err[ST_ERR4] = 1'b1;
                        next_r.err[ST_ERR5] = 1'b1;
                    end else if (!r.supply) begin
                        next_r.err[ST_ERR3] = 1'b1;
                    end else if (r.protect[blk_of(ca)]) begin
                        next_r.err[ST_ERR1] = 1'b1;
                    end else begin
                        next_r.state = S_ERASE;
                    end
                end
                S_BCK_SET: begin
                    next_r.state = S_IDLE;
                    next_r.op_idx = '0;
                    next_r.bank_mode[bank_of(ca)] = MODE_STATUS;
                    if (code != C_BCK_CONFIRM || blk_of(ca) != blk_of(r.op_addr)) begin
                        next_r.err[ST_ERR4] = 1'b1;
                        next_r.err[ST_ERR5] = 1'b1;
                    end else begin
                        next_r.state = S_BLANK;
                    end
                end
                S_PRG_SET: begin
                    next_r.state = S_IDLE;
                    next_r.op_addr = ca;
                    next_r.op_data = cd;
                    next_r.bank_mode[bank_of(ca)] = MODE_STATUS;
                    if (!r.supply) begin
                        next_r.err[ST_ERR3] = 1'b1;
                    end else if (r.protect[blk_of(ca)]) begin
                        next_r.err[ST_ERR1] = 1'b1;
                    end else begin
                        next_r.state = S_PROG;
                    end
                end
                S_BUF_CNT: begin
                    next_r.buf_n = cd[BI_W-1:0];
                    next_r.buf_left = (BI_W + 1)'(cd[BI_W-1:0]) + 1'b1;
                    next_r.buf_started = 1'b0;
                    next_r.state = S_BUF_LOAD;
                    if (blk_of(ca) != blk_of(r.op_addr) || cd > 16'(BUF_WORDS - 1)) begin
                        next_r.err[ST_ERR4] = 1'b1;
                        next_r.err[ST_ERR5] = 1'b1;
                        next_r.state = S_IDLE;
                    end
                end
                S_BUF_LOAD: begin
                    // first load fixes the start address of the window
                    ridx = r.buf_started ? ADDR_W'(ca - r.buf_start) : '0;
                    if (blk_of(ca) != blk_of(r.op_addr) ||
                        (r.buf_started && (ca < r.buf_start ||
                         ridx > ADDR_W'(r.buf_n)))) begin
                        next_r.err[ST_ERR4] = 1'b1;
                        next_r.state = S_IDLE;
                    end else begin
                        buf_we = 1'b1;
                        buf_wi = ridx[BI_W-1:0];
                        if (!r.buf_started) begin
                            next_r.buf_start = ca;
                            next_r.buf_started = 1'b1;
                        end
                        next_r.buf_left = r.buf_left - 1'b1;
                        if (r.buf_left == (BI_W + 1)'(1)) begin
                            next_r.state = S_BUF_CONF;
                        end
                    end
                end
                S_BUF_CONF: begin
                    next_r.state = S_IDLE;
                    next_r.op_idx = '0;
                    if (code != C_CONFIRM) begin
                        next_r.err[ST_ERR4] = 1'b1;
                        next_r.err[ST_ERR5] = 1'b1;
                    end else if (!r.supply) begin
                        next_r.err[ST_ERR3] = 1'b1;
                    end else if (r.protect[blk_of(r.op_addr)]) begin
                        next_r.err[ST_ERR1] = 1'b1;
                    end else begin
                        next_r.state = S_BUF_PROG;
                    end
                end
                S_BLANK: begin
                    // only the status read survives a running check
                    if (code == C_RD_STATUS) begin
                        next_r.bank_mode[bank_of(ca)] = MODE_STATUS;
                    end
                end
                default: begin
                    // erase or program running: read modes only, suspend not built
                    if (read_cmd) begin
                        next_r.bank_mode[bank_of(ca)] = (code == C_RD_ARRAY) ? MODE_ARRAY :
                            (code == C_RD_STATUS) ? MODE_STATUS :
                            (code == C_RD_SIG) ? MODE_SIG : MODE_QUERY;
                    end
                end
            endcase
        end

        // ------------------------------------------------------------
        // reset pin aborts whatever runs; partly erased data stays as is
        // ------------------------------------------------------------
        if (!reset_pin_n) begin
            next_r.state = S_IDLE;
            next_r.bank_mode = '0;
            next_r.err = RST_ERR;
            mem_we = 1'b0;
            buf_we = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{state: S_IDLE, bank_mode: '0, err: RST_ERR, op_addr: '0,
                   op_data: '0, op_idx: '0, buf_n: '0, buf_start: '0,
                   buf_left: '0, buf_started: 1'b0, div_cnt: 8'h00, cmd: RST_CMD,
                   raddr: RST_RADDR, supply: RST_SUPPLY, protect: '0,
                   prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    // array has no reset: contents survive like non-volatile storage
    always_ff @(posedge pclk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
endmodule : fsq_seq

/* sim/fsq_seq_monitor.sv */
// apb and status checks for the flash command sequencer
module fsq_seq_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic reset_pin_n
);
    import fsq_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic st_rd;
    logic vld;
    logic [7:0] last;
    assign acc = psel && penable && pready;
    assign st_rd = acc && !pwrite && paddr == OFF_STATUS;
    // snapshot dropped on command writes and on the reset pin: only those may lower status bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) vld <= 1'b0;
        else if (!reset_pin_n || (acc && pwrite && paddr == OFF_CMD)) vld <= 1'b0;
        else if (st_rd) vld <= 1'b1;
    end
    always_ff @(posedge pclk) begin
        if (st_rd) last <= prdata[7:0];
    end
    chk_ready_one_wait: assert property (psel && !penable |=> pready)
        else $error("pready missing in access cycle");
    chk_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside access cycle");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("pready held two cycles");
    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_unmapped_err: assert property (acc && paddr > OFF_PROTECT |-> pslverr)
        else $error("unmapped access not refused");
    chk_unmapped_zero: assert property (acc && !pwrite && paddr > OFF_PROTECT |-> prdata == 0)
        else $error("unmapped read data not zero");
    chk_mapped_ok: assert property (acc && paddr <= OFF_PROTECT && paddr[1:0] == 0 |-> !pslverr)
        else $error("mapped access refused");
    chk_status_spare: assert property (st_rd |-> prdata[31:8] == 0 && !prdata[6] && !prdata[2])
        else $error("unused status bits set");
    chk_status_sticky: assert property (st_rd && vld |-> (prdata[7:0] & last) == last)
        else $error("status bit dropped without command");
    cover property (st_rd && !prdata[ST_READY]);
    cover property (acc && pslverr);
    cover property (st_rd && prdata[ST_ERR5]);
endmodule : fsq_seq_monitor
bind fsq_seq fsq_seq_monitor fsq_seq_monitor_inst (.*);

/* sim/fsq_host.sv */
// apb master model standing in for the host controller
module fsq_host (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    // request held until pready is sampled; no wait count assumed
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask : xfer
endmodule : fsq_host

/* sim/fsq_seq_tb.sv */
// self-checking bench for the flash command sequencer
module fsq_seq_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fsq_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic reset_pin_n = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    always #10 pclk = ~pclk;
    fsq_seq #(.TICK_DIV(2)) fsq_seq_inst (.*);
    fsq_host fsq_host_inst (.*);
    // ------------------------------------------------------------
    // bus helpers
    // ------------------------------------------------------------
    task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d);
        fsq_host_inst.xfer(w, a, d, q, e);
    endtask : rw
    task automatic chk(input logic [7:0] a, input logic [31:0] x);
        rw(1'b0, a, 32'h0);
        compares++;
        if (q !== x) begin
            num_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, q, x);
        end
    endtask : chk
    task automatic cmd(input logic [7:0] a, input logic [15:0] d);
        rw(1'b1, OFF_CMD, {8'h0, a, d});
    endtask : cmd
    task automatic wait_rdy();
        q = 32'h0;
        for (int i = 0; i < 400 && q[ST_READY] !== 1'b1; i++) rw(1'b0, OFF_STATUS, 32'h0);
        compares++;
        if (q[ST_READY] !== 1'b1) begin
            num_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, q, 32'h80);
        end
    endtask : wait_rdy
    task automatic arr(input logic [7:0] a, input logic [31:0] x);
        cmd(a, 16'hFF);
        rw(1'b1, OFF_RADDR, {24'h0, a});
        chk(OFF_RDATA, x);
    endtask : arr
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        chk(OFF_STATUS, 32'h80);
        chk(8'h18, 32'h0);
        cmd(8'h00, 16'hBC);
        cmd(8'h00, 16'hCB);
        chk(OFF_STATUS, 32'h80);
        rw(1'b1, OFF_CTRL, 32'h1);
        chk(OFF_CTRL, 32'h1);
    endtask : t_regs
    task automatic t_erase();
        cmd(8'h00, 16'h20);
        cmd(8'h00, 16'hD0);
        rw(1'b1, OFF_RADDR, 32'h5);
        chk(OFF_RDATA, 32'h0);
        wait_rdy();
        arr(8'h05, 32'hFFFF);
        cmd(8'h00, 16'hBC);
        cmd(8'h3F, 16'hCB);
        wait_rdy();
        chk(OFF_RDATA, 32'h80);
        cmd(8'h05, 16'h10);
        cmd(8'h05, 16'h1234);
        wait_rdy();
        arr(8'h05, 32'h1234);
    endtask : t_erase
    task automatic t_errs();
        cmd(8'h00, 16'hBC);
        cmd(8'h00, 16'hCB);
        wait_rdy();
        chk(OFF_STATUS, 32'hA0);
        cmd(8'h00, 16'h50);
        chk(OFF_STATUS, 32'h80);
        cmd(8'h00, 16'h20);
        cmd(8'h00, 16'h55);
        cmd(8'h00, 16'hFF);
        chk(OFF_STATUS, 32'hB0);
        cmd(8'h00, 16'h50);
        cmd(8'h00, 16'hBC);
        cmd(8'h00, 16'h55);
        chk(OFF_STATUS, 32'hB0);
        cmd(8'h00, 16'h50);
        rw(1'b1, OFF_PROTECT, 32'h1);
        cmd(8'h05, 16'h40);
        cmd(8'h05, 16'h0);
        wait_rdy();
        chk(OFF_STATUS, 32'h82);
        arr(8'h05, 32'h1234);
        cmd(8'h00, 16'h50);
    endtask : t_errs
    task automatic t_busy();
        cmd(8'h40, 16'h20);
        cmd(8'h40, 16'hD0);
        cmd(8'h00, 16'h20);
        cmd(8'h00, 16'hD0);
        chk(OFF_STATUS, 32'h0);
        cmd(8'h40, 16'hFF);
        chk(OFF_RDATA, 32'h1234);
        cmd(8'h40, 16'h90);
        chk(OFF_RDATA, 32'h0);
        cmd(8'h40, 16'h98);
        chk(OFF_RDATA, 32'h0);
        cmd(8'h40, 16'h70);
        chk(OFF_RDATA, 32'h0);
        reset_pin_n <= 1'b0;
        repeat (2) @(posedge pclk);
        reset_pin_n <= 1'b1;
        chk(OFF_STATUS, 32'h80);
        arr(8'h05, 32'h1234);
        cmd(8'h40, 16'h20);
        cmd(8'h40, 16'hD0);
        wait_rdy();
    endtask : t_busy
    task automatic t_buf();
        cmd(8'h40, 16'hE8);
        chk(OFF_STATUS, 32'h80);
        cmd(8'h40, 16'h1);
        cmd(8'h40, 16'hA5A5);
        cmd(8'h41, 16'h5A5A);
        cmd(8'h40, 16'hD0);
        wait_rdy();
        arr(8'h41, 32'h5A5A);
        cmd(8'h40, 16'hE8);
        cmd(8'h40, 16'h1);
        cmd(8'h42, 16'h1111);
        cmd(8'h44, 16'h2222);
        chk(OFF_STATUS, 32'h90);
        arr(8'h42, 32'hFFFF);
    endtask : t_buf
    task automatic test_done();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : test_done
    // hang guard well above the longest expected run
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            test_done();
        end
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_erase();
        t_errs();
        t_busy();
        t_buf();
        test_done();
    end
endmodule : fsq_seq_tb
